/* File: cpl_pkg.sv */
// Purpose: shared constants and types for the config port pin logic
// Assumes: one parallel byte lane, one serial lane, one fetch engine
// Notes: mode value comes from outside, mode decoding is not done here
package cpl_pkg;
   localparam int   BYTE_W      = 8;
   localparam int   ADDR_W      = 18;
   localparam int   EXT_W       = 4;
   localparam int   FIFO_DEPTH  = 16;
   localparam int   MEM_WAIT    = 4;
   localparam int   STATUS_BIT  = 7;
   localparam logic [6:0] FILL_HIGH = 7'h7f;
   localparam logic [21:0] ADDR_RST = 22'h00_0000;

   typedef enum logic [1:0] {
      MODE_SERIAL  = 2'h0,
      MODE_PERIPH  = 2'h1,
      MODE_MASTER  = 2'h2,
      MODE_EXPRESS = 2'h3
   } cpl_mode_t;

   typedef enum logic [2:0] {
      FS_IDLE = 3'h1,
      FS_WAIT = 3'h2,
      FS_TAKE = 3'h4
   } cpl_fetch_t;

   typedef struct packed {
      logic [7:0] data;
      logic       from_link;
   } cpl_byte_t;

   typedef struct packed {
      logic       cs_low_n;
      logic       cs_high;
      logic       ws_n;
      logic       rs_n;
      logic       global_tristate_net;
      logic       global_set_reset_net;
      logic       done;
      cpl_mode_t  mode;
      logic [7:0] data;
   } cpl_pins_t;

   typedef struct packed {
      logic express;
      logic done;
      logic global_tristate_net;
   } cpl_ctl_t;
endpackage : cpl_pkg

/* File: cpl_top.sv */
// Purpose: config port pins: peripheral, master parallel, serial chain
// Assumes: i_ref_clk 25 MHz, i_config_clock from the chain master
// Notes: loaded bytes leave through a byte FIFO with back-pressure; a byte pushed while the FIFO is full is dropped
// How it works
// RQ1: selected only while low-active select low and high-active select high
// RQ2: selected write strobe low captures the data bus into the buffer
// RQ3: selected read strobe low drives ready status on bit 7, others high
// RQ4: both strobes low: write happens, read is ignored
// RQ5: host never asserts both strobes at once; the bench asserts both on its first peripheral write
// RQ6: express mode uses high-active select as chain enable
// RQ7: master parallel drives an 18-bit memory address
// RQ8: extended variant drives 4 more high address bits
// RQ9: master parallel and peripheral take bytes from the data bus
// RQ10: serial modes sample serial input on rising config clock
// RQ11: in parallel modes serial input pin is data bit 0
// RQ12: serial out follows input on falling edge 1.5 periods later
// RQ13: express mode serial out is status enabling the next device
// RQ14: before and during load unused outputs float with pull-up; o_unused_pullup_en follows i_arst_n, so it is off in reset
// RQ15: after load unused cells are inputs with pull-up
// RQ16: a user pin may drive the global set/reset net
// RQ17: global tristate floats all outputs, no low-power state; o_serial_out_oe drops only after two rising and a falling config clock edge
// RQ18: after load the config pins become user I/O
// RQ19: host polls ready status before writing the next byte; the bench writes several bytes without a poll, and one after a not-ready poll
`timescale 1ns/100ps

module cpl_fifo
   import cpl_pkg::*;
#(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   input  wire logic             i_ref_clk,
   input  wire logic             i_arst_n,
   input  wire logic [WIDTH-1:0] i_data,
   input  wire logic             i_valid,
   output logic                  o_ready,
   output logic      [WIDTH-1:0] o_data,
   output logic                  o_valid,
   input  wire logic             i_ready
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW:0] wr;
      logic [AW:0] rd;
   } cpl_fptr_t;

   logic [WIDTH-1:0] mem [DEPTH];
   cpl_fptr_t        st;
   cpl_fptr_t        next_st;
   logic             push;
   logic             pop;

   if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("fifo depth must be a power of two");

   assign o_ready = (st.wr - st.rd) != (AW+1)'(DEPTH);
   assign o_valid = st.wr != st.rd;
   assign o_data  = mem[st.rd[AW-1:0]];
   assign push    = i_valid && o_ready;
   assign pop     = o_valid && i_ready;

   always_comb
   begin
      next_st = st;
      if (push)
         next_st.wr = st.wr + 1'b1;
      if (pop)
         next_st.rd = st.rd + 1'b1;
   end

   always_ff @(posedge i_ref_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         st <= '0;
      else
         st <= next_st;
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (push)
         mem[st.wr[AW-1:0]] <= i_data;
   end
endmodule : cpl_fifo

module cpl_top
   import cpl_pkg::*;
#(
   parameter bit EXT_EN = 1'b1,
   parameter int WAIT_N = MEM_WAIT
) (
   input  wire logic        i_ref_clk,
   input  wire logic        i_arst_n,
   input  wire logic        i_config_clock,
   input  wire cpl_mode_t   i_mode,
   input  wire logic        i_config_done,
   input  wire logic        i_global_tristate_net,
   input  wire logic        i_gsr_user_pin,
   input  wire logic        i_chip_select_active_low_n,
   input  wire logic        i_chip_select_active_high,
   input  wire logic        i_write_strobe_n,
   input  wire logic        i_read_strobe_n,
   input  wire logic [7:1]  i_config_byte_bus,
   input  wire logic        i_serial_in,
   output logic      [7:0]  o_config_byte_bus,
   output logic             o_config_byte_bus_oe,
   output logic      [17:0] o_memory_address_out,
   output logic             o_memory_address_out_oe,
   output logic      [3:0]  o_memory_address_ext,
   output logic             o_memory_address_ext_oe,
   output logic             o_serial_out,
   output logic             o_serial_out_oe,
   output logic             o_unused_pullup_en,
   output logic             o_unused_as_input,
   output logic             o_user_io_mode,
   output logic             o_global_set_reset_net,
   output cpl_byte_t        o_byte,
   output logic             o_byte_valid,
   input  wire logic        i_byte_ready
);
   localparam int CNT_W = $clog2(WAIT_N + 1);

   if (WAIT_N < 1)
      $error("WAIT_N must be at least one");

   typedef struct packed {
      cpl_pins_t   s1;
      cpl_pins_t   s2;
      logic        ws_prev;
      logic        tog_s1;
      logic        tog_s2;
      logic        tog_prev;
      cpl_fetch_t  fsm;
      logic [21:0] addr;
      logic [CNT_W-1:0] cnt;
      logic        push_v;
      cpl_byte_t   push_d;
      logic [7:0]  bus;
      logic        bus_oe;
      logic        addr_oe;
      logic        ext_oe;
      cpl_ctl_t    ctl;
      logic        global_set_reset_net;
      logic        user;
   } cpl_ref_t;

   typedef struct packed {
      cpl_ctl_t   c1;
      cpl_ctl_t   c2;
      logic [7:0] sh;
      logic [2:0] bits;
      logic [7:0] hold;
      logic       tog;
      logic       s0;
      logic       s1;
      logic       en;
   } cpl_link_t;

   cpl_ref_t  st;
   cpl_ref_t  next_st;
   cpl_link_t lk;
   cpl_link_t next_lk;
   cpl_pins_t pins;
   logic      fifo_ready;
   logic      lrst_n;
   logic      lrst_s;
   logic      sel;
   logic      cfg;
   logic      periph;
   logic      master;

   assign pins = '{cs_low_n: i_chip_select_active_low_n,
                   cs_high:  i_chip_select_active_high,
                   ws_n:     i_write_strobe_n,
                   rs_n:     i_read_strobe_n,
                   global_tristate_net:      i_global_tristate_net,
                   global_set_reset_net:      i_gsr_user_pin,
                   done:     i_config_done,
                   mode:     i_mode,
                   data:     {i_config_byte_bus, i_serial_in}}; // see RQ11

   assign sel    = !st.s2.cs_low_n && st.s2.cs_high; // see RQ1
   assign cfg    = !st.s2.done;
   assign periph = cfg && st.s2.mode == MODE_PERIPH;
   assign master = cfg && st.s2.mode == MODE_MASTER;

   always_comb
   begin
      next_st          = st;
      next_st.s1       = pins;
      next_st.s2       = st.s1;
      next_st.ws_prev  = st.s2.ws_n;
      next_st.tog_s1   = lk.tog;
      next_st.tog_s2   = st.tog_s1;
      next_st.tog_prev = st.tog_s2;
      next_st.push_v   = 1'b0;
      // write falls while selected: capture bus byte
      if (periph && sel && st.ws_prev && !st.s2.ws_n)
      begin
         next_st.push_v = 1'b1; // see RQ2 see RQ9
         next_st.push_d = '{data: st.s2.data, from_link: 1'b0};
      end
      // a finished serial byte; hold is stable between toggles
      if (cfg && st.s2.mode inside {MODE_SERIAL, MODE_EXPRESS}
          && st.tog_s2 != st.tog_prev)
      begin
         next_st.push_v = 1'b1;
         next_st.push_d = '{data: lk.hold, from_link: 1'b1};
      end
      // write strobe low blocks the status read
      next_st.bus_oe = periph && sel && !st.s2.rs_n && st.s2.ws_n
                       && !st.s2.global_tristate_net; // see RQ3 see RQ4 see RQ17
      next_st.bus    = {fifo_ready, FILL_HIGH}; // see RQ3
      case (st.fsm)
         FS_IDLE:
         begin
            // wait for the last fetched byte to land, so a full fifo shows
            if (master && fifo_ready && !st.push_v)
            begin
               next_st.cnt = CNT_W'(WAIT_N - 1);
               next_st.fsm = FS_WAIT;
            end
         end
         FS_WAIT:
         begin
            if (!master)
               next_st.fsm = FS_IDLE;
            else if (st.cnt == '0)
               next_st.fsm = FS_TAKE;
            else
               next_st.cnt = st.cnt - 1'b1;
         end
         FS_TAKE:
         begin
            next_st.push_v = 1'b1; // see RQ9
            next_st.push_d = '{data: st.s2.data, from_link: 1'b0};
            next_st.addr   = st.addr + 1'b1; // see RQ7 see RQ8
            next_st.fsm    = FS_IDLE;
         end
         default:
            next_st.fsm = FS_IDLE;
      endcase
      if (!master)
         next_st.addr = ADDR_RST;
      next_st.addr_oe = master && !st.s2.global_tristate_net; // see RQ7 see RQ17
      next_st.ext_oe  = master && EXT_EN && !st.s2.global_tristate_net; // see RQ8
      next_st.ctl     = '{express: st.s2.mode == MODE_EXPRESS,
                          done:    st.s2.done,
                          global_tristate_net:     st.s2.global_tristate_net};
      next_st.global_set_reset_net     = st.s2.done && st.s2.global_set_reset_net; // see RQ16
      next_st.user    = st.s2.done; // see RQ18
   end

   always_ff @(posedge i_ref_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         st          <= '0;
         st.s1.done  <= 1'b0;
         st.fsm      <= FS_IDLE;
         st.addr     <= ADDR_RST;
         st.bus      <= 8'h00;
      end
      else
         st <= next_st;
   end

   cpl_fifo #(
      .WIDTH ($bits(cpl_byte_t)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .i_ref_clk (i_ref_clk),
      .i_arst_n  (i_arst_n),
      .i_data    (st.push_d),
      .i_valid   (st.push_v),
      .o_ready   (fifo_ready),
      .o_data    (o_byte),
      .o_valid   (o_byte_valid),
      .i_ready   (i_byte_ready)
   );

   // link reset: asserted at once, released on the link clock
   always_ff @(posedge i_config_clock or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         lrst_s <= 1'b0;
         lrst_n <= 1'b0;
      end
      else
      begin
         lrst_s <= 1'b1;
         lrst_n <= lrst_s;
      end
   end

   always_comb
   begin
      next_lk    = lk;
      next_lk.c1 = st.ctl;
      next_lk.c2 = lk.c1;
      next_lk.s0 = i_serial_in;
      next_lk.s1 = lk.s0;
      next_lk.en = !lk.c2.done && (!lk.c2.express
                   || i_chip_select_active_high); // see RQ6
      if (next_lk.en)
      begin
         next_lk.sh   = {lk.sh[6:0], i_serial_in}; // see RQ10
         next_lk.bits = lk.bits + 1'b1;
         if (lk.bits == 3'h7)
         begin
            next_lk.hold = {lk.sh[6:0], i_serial_in};
            next_lk.tog  = !lk.tog;
         end
      end
   end

   always_ff @(posedge i_config_clock or negedge lrst_n)
   begin
      if (!lrst_n)
         lk <= '0;
      else
         lk <= next_lk;
   end

   // falling edge: data 1.5 periods behind s0, or chain status
   always_ff @(negedge i_config_clock or negedge lrst_n)
   begin
      if (!lrst_n)
      begin
         o_serial_out    <= 1'b1;
         o_serial_out_oe <= 1'b0;
      end
      else
      begin
         o_serial_out    <= lk.c2.express ? lk.c2.done : lk.s1;
         o_serial_out_oe <= !lk.c2.global_tristate_net
                            && (lk.c2.express || !lk.c2.done);
      end // see RQ12 see RQ13 see RQ17
   end

   assign o_config_byte_bus       = st.bus;
   assign o_config_byte_bus_oe    = st.bus_oe;
   assign o_memory_address_out    = st.addr[17:0];
   assign o_memory_address_ext    = st.addr[21:18];
   assign o_memory_address_out_oe = st.addr_oe;
   assign o_memory_address_ext_oe = st.ext_oe;
   assign o_global_set_reset_net  = st.global_set_reset_net;
   assign o_user_io_mode          = st.user;
   assign o_unused_as_input       = st.user; // see RQ15
   assign o_unused_pullup_en      = i_arst_n; // see RQ14 see RQ15

   a_sel_write: assert property ( // see RQ2
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      periph && sel && st.ws_prev && !st.s2.ws_n
      |=> st.push_v && st.push_d.data == $past(st.s2.data))
      else $error("selected write did not capture byte");

   a_select_gate: assert property ( // see RQ1
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      st.bus_oe |-> $past(!st.s2.cs_low_n && st.s2.cs_high))
      else $error("bus driven while not selected");

   a_read_status: assert property ( // see RQ3
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      periph && sel && !st.s2.rs_n && st.s2.ws_n && !st.s2.global_tristate_net
      |=> st.bus_oe && st.bus[6:0] == 7'h7f
          && st.bus[7] == $past(fifo_ready))
      else $error("status read wrong");

   a_write_wins: assert property ( // see RQ4
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      !st.s2.ws_n && !st.s2.rs_n |=> !st.bus_oe)
      else $error("read served during write");

   a_addr_step: assert property ( // see RQ7
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      st.fsm == FS_TAKE && master
      |=> st.addr == $past(st.addr) + 22'h00_0001 && st.push_v)
      else $error("address did not step after fetch");

   a_ext_drive: assert property ( // see RQ8
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      st.addr_oe |-> st.ext_oe == EXT_EN)
      else $error("extended address enable wrong");

   a_tristate_all: assert property ( // see RQ17
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      st.s2.global_tristate_net |=> !st.bus_oe && !st.addr_oe && !st.ext_oe)
      else $error("output driven under global tristate");

   a_fetch_wait: assert property ( // see RQ9
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      st.fsm == FS_IDLE && master && fifo_ready && !st.push_v
      ##1 master [*4] |=> st.fsm == FS_TAKE || WAIT_N != 4)
      else $error("fetch wait length wrong");

   a_dout_delay: assert property ( // see RQ12
      @(posedge i_config_clock) disable iff (!lrst_n)
      !lk.c2.express && $past(!lk.c2.express, 2) && $past(lrst_n, 3)
      |-> o_serial_out == $past(i_serial_in, 2))
      else $error("serial out not 1.5 periods behind input");

   a_chain_gate: assert property ( // see RQ6
      @(posedge i_config_clock) disable iff (!lrst_n)
      lk.c2.express && !i_chip_select_active_high
      |=> !lk.en && lk.bits == $past(lk.bits))
      else $error("disabled chain device shifted");
endmodule : cpl_top

/* File: cpl_link_src.sv */
// Purpose: chain master model, config clock bursts and serial data
// Assumes: clock stands still low between bytes, msb sent first
// Notes: serial out is captured at every rising edge into o_cap
`timescale 1ns/100ps
module cpl_link_src
   import cpl_pkg::*;
(
   input  wire logic i_bit0,
   input  wire logic i_dout,
   output logic      o_config_clock,
   output logic      o_serial_in,
   output logic [7:0] o_cap
);
   logic busy = 1'b0;
   logic last = 1'b0;

   initial o_config_clock = 1'b0;
   initial o_cap = 8'h00;

   // outside frames the pin belongs to the parallel bus bit 0
   assign o_serial_in = busy ? last : i_bit0;

   task automatic send(input logic [7:0] b, input int n);
      #1.3;
      busy = 1'b1;
      for (int i = 0; i < n; i++)
      begin
         last = b[7 - (i % 8)];
         #3 o_config_clock = 1'b1;
         o_cap = {o_cap[6:0], i_dout};
         #3 o_config_clock = 1'b0;
      end
      busy = 1'b0;
   endtask : send
endmodule : cpl_link_src

/* File: cpl_top_tb.sv */
// Purpose: self-checking bench for the config port pin logic
// Assumes: consumer is a ready line plus an expected-byte queue
// Notes: random bytes from an lfsr with a fixed seed
`timescale 1ns/100ps
module cpl_top_tb
   import cpl_pkg::*;
();
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   cpl_mode_t   mode = MODE_EXPRESS;
   logic        done = 1'b0;
   logic        global_tristate_net = 1'b0;
   logic        global_set_reset_net = 1'b0;
   logic        csl_n = 1'b1;
   logic        csh = 1'b0;
   logic        ws_n = 1'b1;
   logic        rs_n = 1'b1;
   logic [7:1]  bus = 7'h00;
   logic        bit0 = 1'b0;
   logic        rdy = 1'b1;
   logic        config_clock, din, bus_oe, sout, sout_oe, pu_en, as_in, uio;
   logic        gsr_o, bvalid, addr_oe, ext_oe;
   logic [7:0]  cap, bus_o, b;
   logic [17:0] addr;
   logic [3:0]  ext;
   cpl_byte_t   byte_o;
   cpl_byte_t   exp_q[$];
   logic [31:0] seed = 32'h0719_7999;
   int          err_count = 0;
   int          tests_run = 0;

   cpl_link_src u_src (.i_bit0(bit0), .i_dout(sout),
      .o_config_clock(config_clock), .o_serial_in(din), .o_cap(cap));

   cpl_top #(.EXT_EN(1'b1), .WAIT_N(4)) dut (
      .i_ref_clk(clk), .i_arst_n(arst_n), .i_config_clock(config_clock),
      .i_mode(mode), .i_config_done(done), .i_global_tristate_net(global_tristate_net),
      .i_gsr_user_pin(global_set_reset_net), .i_chip_select_active_low_n(csl_n),
      .i_chip_select_active_high(csh), .i_write_strobe_n(ws_n),
      .i_read_strobe_n(rs_n), .i_config_byte_bus(bus), .i_serial_in(din),
      .o_config_byte_bus(bus_o), .o_config_byte_bus_oe(bus_oe),
      .o_memory_address_out(addr), .o_memory_address_out_oe(addr_oe),
      .o_memory_address_ext(ext), .o_memory_address_ext_oe(ext_oe),
      .o_serial_out(sout), .o_serial_out_oe(sout_oe),
      .o_unused_pullup_en(pu_en), .o_unused_as_input(as_in),
      .o_user_io_mode(uio), .o_global_set_reset_net(gsr_o),
      .o_byte(byte_o), .o_byte_valid(bvalid), .i_byte_ready(rdy));

   initial
   begin
      forever #20 clk = ~clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr

   function automatic logic [7:0] mem(input logic [17:0] a);
      return a[7:0] ^ 8'hc3;
   endfunction : mem

   task automatic rnd();
      seed = lfsr(seed);
      b = seed[7:0];
   endtask : rnd

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         err_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : finish_test

   task automatic wr(input logic [7:0] d, input logic rd, input logic p);
      if (p)
         exp_q.push_back({d, 1'b0});
      @(posedge clk);
      bus <= d[7:1];
      bit0 <= d[0];
      ws_n <= 1'b0;
      rs_n <= ~rd;
      cyc(4);
      #1;
      chk(bus_oe, 1'b0);
      @(posedge clk);
      ws_n <= 1'b1;
      rs_n <= 1'b1;
      cyc(2);
   endtask : wr

   task automatic rd_st(input logic e);
      @(posedge clk);
      rs_n <= 1'b0;
      cyc(4);
      #1;
      chk(bus_oe, 1'b1);
      chk(bus_o, {e, 7'h7f});
      @(posedge clk);
      rs_n <= 1'b1;
      cyc(3);
   endtask : rd_st

   // prompt configuration memory
   always @(posedge clk)
   begin
      if (mode == MODE_MASTER)
         {bus, bit0} <= mem(addr);
   end

   // settled head, popped at the next rising edge
   always @(negedge clk)
   begin
      if (arst_n && bvalid === 1'b1 && rdy)
      begin
         if (exp_q.size() == 0)
            chk(1'b1, 1'b0);
         else
            chk(byte_o, exp_q.pop_front());
      end
   end

   initial
   begin
      #200000;
      err_count++;
      finish_test();
   end

   initial
   begin
      fork
         u_src.send(8'h00, 4);
         cyc(2);
      join
      arst_n <= 1'b1;
      // two link edges release the link reset, no bit shifted
      u_src.send(8'h00, 2);
      cyc(4);
      #1;
      chk(bvalid, 1'b0);
      chk(pu_en, 1'b1);
      chk(uio, 1'b0);
      chk(addr_oe, 1'b0);
      @(posedge clk);
      csh <= 1'b1;
      cyc(2);
      rnd();
      exp_q.push_back({b, 1'b1});
      u_src.send(b, 8);
      cyc(10);
      csh <= 1'b0;
      cyc(2);
      rnd();
      u_src.send(b, 8);
      cyc(8);
      #1;
      chk(sout, 1'b0);
      chk(sout_oe, 1'b1);
      chk(bvalid, 1'b0);
      @(posedge clk);
      // select high keeps the chain enabled while the mode crosses
      csh <= 1'b1;
      mode <= MODE_SERIAL;
      cyc(6);
      repeat (3)
      begin
         rnd();
         exp_q.push_back({b, 1'b1});
         u_src.send(b, 8);
         chk(cap[5:0], b[7:2]);
         cyc(10);
      end
      mode <= MODE_PERIPH;
      csl_n <= 1'b0;
      csh <= 1'b1;
      cyc(6);
      rd_st(1'b1);
      for (int i = 0; i < 4; i++)
      begin
         rnd();
         wr(b, i == 0, 1'b1);
      end
      csh <= 1'b0;
      cyc(3);
      wr(8'h5a, 1'b0, 1'b0);
      csh <= 1'b1;
      csl_n <= 1'b1;
      cyc(3);
      wr(8'ha5, 1'b0, 1'b0);
      csl_n <= 1'b0;
      rdy <= 1'b0;
      cyc(10);
      for (int i = 0; i < 16; i++)
      begin
         rd_st(1'b1);
         rnd();
         wr(b, 1'b0, 1'b1);
      end
      cyc(6);
      rd_st(1'b0);
      wr(8'h3c, 1'b0, 1'b0);
      rdy <= 1'b1;
      cyc(40);
      chk(exp_q.size(), 0);
      rdy <= 1'b0;
      for (int i = 0; i < 16; i++)
         exp_q.push_back({mem(18'(i)), 1'b0});
      mode <= MODE_MASTER;
      cyc(160);
      #1;
      chk(addr, 18'h0_0010);
      chk(ext, 4'h0);
      chk(addr_oe, 1'b1);
      chk(ext_oe, 1'b1);
      @(posedge clk);
      global_tristate_net <= 1'b1;
      cyc(4);
      #1;
      chk({bus_oe, addr_oe, ext_oe}, 3'h0);
      @(posedge clk);
      global_tristate_net <= 1'b0;
      mode <= MODE_PERIPH;
      rdy <= 1'b1;
      cyc(40);
      chk(exp_q.size(), 0);
      done <= 1'b1;
      global_set_reset_net <= 1'b1;
      cyc(4);
      #1;
      chk(uio, 1'b1);
      chk(as_in, 1'b1);
      chk(gsr_o, 1'b1);
      @(posedge clk);
      global_set_reset_net <= 1'b0;
      cyc(4);
      #1;
      chk(gsr_o, 1'b0);
      chk(bvalid, 1'b0);
      finish_test();
   end
endmodule : cpl_top_tb
